/* hw/nci_pkg.sv */
package nci_pkg;
  // geometry
  localparam int PC_W = 14;
  localparam int RAM_WORDS = 512;
  localparam int STACK_DEPTH = 8;
  localparam int NUM_SRC = 8;
  localparam int PORT_D_W = 10;
  localparam logic [2:0] SP_RESET = 3'h7;
  localparam logic [6:0] VEC_PAGE = 7'h01;
  localparam logic [6:0] PAGE2 = 7'h02;
  // instruction clock: system clock divided by 3
  localparam logic [1:0] DIV_LAST = 2'h2;
  localparam logic [1:0] DIV_FETCH = 2'h0;
  // major opcodes, instr[9:6]
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_ADDI = 4'h1;
  localparam logic [3:0] OP_LA = 4'h2;
  localparam logic [3:0] OP_RBIT = 4'h3;
  localparam logic [3:0] OP_PBIT = 4'h4;
  localparam logic [3:0] OP_TABP = 4'h5;
  localparam logic [3:0] OP_LX = 4'h6;
  localparam logic [3:0] OP_LY = 4'h7;
  localparam logic [3:0] OP_LZ = 4'h8;
  localparam logic [3:0] OP_SNZ = 4'h9;
  localparam logic [3:0] OP_BLA = 4'ha;
  localparam logic [3:0] OP_BMLA = 4'hb;
  // instr[9:7]
  localparam logic [2:0] OP_BM = 3'h6;
  localparam logic [2:0] OP_B = 3'h7;
  // misc sub-ops, instr[5:0]
  localparam logic [5:0] SUB_NOP = 6'h00;
  localparam logic [5:0] SUB_AM = 6'h01;
  localparam logic [5:0] SUB_AMC = 6'h02;
  localparam logic [5:0] SUB_RAR = 6'h03;
  localparam logic [5:0] SUB_SC = 6'h04;
  localparam logic [5:0] SUB_RC = 6'h05;
  localparam logic [5:0] SUB_TEAB = 6'h06;
  localparam logic [5:0] SUB_TABE = 6'h07;
  localparam logic [5:0] SUB_READ_DEPTH_POINTER_INSTR = 6'h08;
  localparam logic [5:0] SUB_RT = 6'h09;
  localparam logic [5:0] SUB_RTI = 6'h0a;
  localparam logic [5:0] SUB_SBK = 6'h0b;
  localparam logic [5:0] SUB_RBK = 6'h0c;
  localparam logic [5:0] SUB_EI = 6'h0d;
  localparam logic [5:0] SUB_DI = 6'h0e;
  localparam logic [5:0] SUB_TV1A = 6'h0f;
  localparam logic [5:0] SUB_TV2A = 6'h10;
  localparam logic [5:0] SUB_TDA = 6'h11;
  localparam logic [5:0] SUB_TAM = 6'h12;
  localparam logic [5:0] SUB_TMA = 6'h13;
  localparam logic [5:0] SUB_AND = 6'h14;
  localparam logic [5:0] SUB_OR = 6'h15;
  localparam logic [5:0] SUB_CMA = 6'h16;
  localparam logic [5:0] SUB_TAV1 = 6'h17;
  localparam logic [5:0] SUB_TAV2 = 6'h18;
  // bit-op kind, instr[5:4]
  localparam logic [1:0] BIT_SET = 2'h0;
  localparam logic [1:0] BIT_CLR = 2'h1;
  localparam logic [1:0] BIT_TEST = 2'h2;
  // register map
  localparam int AXI_AW = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_IRQ_EN = 5'h08;
  localparam logic [4:0] REG_IRQ_FLAGS = 5'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    NCI_EXEC = 2'b01,
    NCI_TABLE = 2'b10
  } nci_state_t;

  typedef struct packed {
    logic z;
    logic [3:0] x;
    logic [3:0] y;
  } nci_locator_t;

  typedef struct packed {
    nci_locator_t loc;
    logic carry;
    logic skip;
    logic [3:0] acc;
    logic [3:0] aux;
  } nci_context_t;

  typedef struct packed {
    logic [7:0] pad;
    logic skip;
    logic gate;
    logic carry;
    logic [2:0] sp;
    logic [3:0] acc;
    logic [13:0] pc;
  } nci_status_t;
endpackage : nci_pkg

/* hw/nci_core.sv */
`timescale 1ns/1ps
module nci_core (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [nci_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [nci_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // program memory
  output logic [nci_pkg::PC_W-1:0] rom_addr,
  input wire logic [9:0] rom_data,
  // peripheral requests
  input wire logic [nci_pkg::NUM_SRC-1:0] irq_src,
  // port D
  output logic [nci_pkg::PORT_D_W-1:0] port_d_out,
  input wire logic [nci_pkg::PORT_D_W-1:0] port_d_in
);
  logic [1:0] div;
  logic run;
  logic tick;
  nci_pkg::nci_state_t state;
  logic [13:0] pc;
  logic [13:0] pc_inc;
  logic [13:0] tbl_addr;
  logic [3:0] acc;
  logic [3:0] aux;
  logic [7:0] pair;
  logic [2:0] page_ptr;
  logic carry_bit;
  logic skip;
  logic gate;
  logic ei_wait;
  logic bank;
  logic irq_arm;
  nci_pkg::nci_locator_t ram_locator;
  nci_pkg::nci_context_t interrupt_context_save;
  logic [2:0] stack_depth_pointer;
  logic [13:0] return_stack_entry [0:nci_pkg::STACK_DEPTH-1];
  logic [3:0] ram [0:nci_pkg::RAM_WORDS-1];
  logic [7:0] flags;
  logic [7:0] enables;
  logic [7:0] pend;
  logic [2:0] win;
  logic irq_hit;
  logic take;
  logic exec;
  logic live;
  logic [3:0] major;
  logic [5:0] op;
  logic [3:0] mem;
  logic [4:0] sum_c;
  logic is_bm;
  logic is_b;
  logic push;
  logic pop;
  logic [13:0] push_val;
  logic ram_we;
  logic [3:0] ram_wdata;
  logic snz_hit;
  logic [7:0] clr;
  logic port_valid;
  logic wr_fire;
  logic rd_fire;
  nci_pkg::nci_status_t status;
  logic [7:0] tbl_hold;

  // instruction clock enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div <= 2'h0;
    end else if (div == nci_pkg::DIV_LAST) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
    end
  end

  assign tick = run && (div == nci_pkg::DIV_LAST);
  assign major = rom_data[9:6];
  assign op = rom_data[5:0];
  assign is_bm = (rom_data[9:7] == nci_pkg::OP_BM);
  assign is_b = (rom_data[9:7] == nci_pkg::OP_B);
  assign mem = ram[ram_locator];
  assign pc_inc = pc + 14'h0001;
  assign sum_c = {1'b0, acc} + {1'b0, mem} + {4'h0, carry_bit};
  assign pair = {aux, acc};
  assign port_valid = (ram_locator.y < 4'(nci_pkg::PORT_D_W));

  // fixed priority: lowest source index wins
  assign pend = flags & enables;
  always_comb begin
    win = 3'h0;
    for (int i = nci_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win = 3'(i);
      end
    end
  end

  assign irq_hit = gate && (pend != 8'h00);
  assign take = tick && (state == nci_pkg::NCI_EXEC) && irq_arm && irq_hit;
  assign exec = tick && (state == nci_pkg::NCI_EXEC) && !take;
  assign live = exec && !skip;
  assign snz_hit = live && !is_bm && !is_b && (major == nci_pkg::OP_SNZ) && flags[op[2:0]]
                   && !enables[op[2:0]];

  // stack control
  always_comb begin
    push = take;
    push_val = pc;
    pop = tick && (state == nci_pkg::NCI_TABLE);
    if (live && !is_b) begin
      if (is_bm || major == nci_pkg::OP_BMLA || major == nci_pkg::OP_TABP) begin
        push = 1'b1;
        push_val = pc_inc;
      end else if (major == nci_pkg::OP_MISC && (op == nci_pkg::SUB_RT || op == nci_pkg::SUB_RTI)) begin
        pop = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_depth_pointer <= nci_pkg::SP_RESET;
    end else if (push) begin
      stack_depth_pointer <= stack_depth_pointer + 3'h1;
    end else if (pop) begin
      stack_depth_pointer <= stack_depth_pointer - 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      return_stack_entry[stack_depth_pointer + 3'h1] <= push_val;
    end
  end

  // data ram bit ops and stores
  always_comb begin
    ram_we = 1'b0;
    ram_wdata = mem;
    if (live && !is_b && !is_bm) begin
      if (major == nci_pkg::OP_RBIT && op[5:4] != nci_pkg::BIT_TEST) begin
        ram_we = 1'b1;
        ram_wdata[op[1:0]] = (op[5:4] == nci_pkg::BIT_SET);
      end else if (major == nci_pkg::OP_MISC && op == nci_pkg::SUB_TMA) begin
        ram_we = 1'b1;
        ram_wdata = acc;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (ram_we) begin
      ram[ram_locator] <= ram_wdata;
    end
  end

  // request flags: a new request wins over a clear in the same cycle
  always_comb begin
    clr = 8'h00;
    if (take) begin
      clr[win] = 1'b1;
    end
    if (snz_hit) begin
      clr[op[2:0]] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= 8'h00;
    end else begin
      flags <= (flags & ~clr) | irq_src;
    end
  end

  // enable bits: software over the bus or the core's own transfers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enables <= 8'h00;
    end else if (wr_fire && s_axi_awaddr == nci_pkg::REG_IRQ_EN && s_axi_wstrb[0]) begin
      enables <= s_axi_wdata[7:0];
    end else if (live && !is_b && !is_bm && major == nci_pkg::OP_MISC && op == nci_pkg::SUB_TV1A) begin
      enables[3:0] <= acc;
    end else if (live && !is_b && !is_bm && major == nci_pkg::OP_MISC && op == nci_pkg::SUB_TV2A) begin
      enables[7:4] <= acc;
    end
  end

  // program memory address, stable well before the next tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rom_addr <= 14'h0000;
    end else if (div == nci_pkg::DIV_FETCH) begin
      rom_addr <= (state == nci_pkg::NCI_TABLE) ? tbl_addr : pc;
    end
  end

  // core sequencing and datapath
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= nci_pkg::NCI_EXEC;
      pc <= 14'h0000;
      tbl_addr <= 14'h0000;
      acc <= 4'h0;
      aux <= 4'h0;
      page_ptr <= 3'h0;
      carry_bit <= 1'b0;
      skip <= 1'b0;
      gate <= 1'b0;
      ei_wait <= 1'b0;
      bank <= 1'b0;
      irq_arm <= 1'b0;
      ram_locator <= '0;
      interrupt_context_save <= '0;
      port_d_out <= 10'h000;
    end else begin
      if (tick) begin
        irq_arm <= irq_hit;
      end
      if (take) begin
        interrupt_context_save <= '{ram_locator, carry_bit, skip, acc, aux};
        skip <= 1'b0;
        pc <= {nci_pkg::VEC_PAGE, 3'h0, win, 1'b0};
        gate <= 1'b0;
        ei_wait <= 1'b0;
      end else if (tick && state == nci_pkg::NCI_TABLE) begin
        {aux, acc} <= rom_data[7:0];
        pc <= return_stack_entry[stack_depth_pointer];
        state <= nci_pkg::NCI_EXEC;
      end else if (exec) begin
        pc <= pc_inc;
        skip <= 1'b0;
        if (ei_wait) begin
          gate <= 1'b1;
          ei_wait <= 1'b0;
        end
        if (!skip) begin
          if (is_b) begin
            pc <= {pc[13:7], rom_data[6:0]};
          end else if (is_bm) begin
            pc <= {nci_pkg::PAGE2, rom_data[6:0]};
          end else begin
            case (major)
              nci_pkg::OP_ADDI: acc <= acc + op[3:0];
              nci_pkg::OP_LA: acc <= op[3:0];
              nci_pkg::OP_LX: ram_locator.x <= op[3:0];
              nci_pkg::OP_LY: ram_locator.y <= op[3:0];
              nci_pkg::OP_LZ: ram_locator.z <= op[0];
              nci_pkg::OP_RBIT: begin
                if (op[5:4] == nci_pkg::BIT_TEST && !mem[op[1:0]]) begin
                  skip <= 1'b1;
                end
              end
              nci_pkg::OP_PBIT: begin
                if (port_valid) begin
                  if (op[5:4] == nci_pkg::BIT_SET) begin
                    port_d_out[ram_locator.y] <= 1'b1;
                  end else if (op[5:4] == nci_pkg::BIT_CLR) begin
                    port_d_out[ram_locator.y] <= 1'b0;
                  end else if (op[5:4] == nci_pkg::BIT_TEST && !port_d_in[ram_locator.y]) begin
                    skip <= 1'b1;
                  end
                end
              end
              nci_pkg::OP_TABP: begin
                tbl_addr <= {bank, op, page_ptr, acc};
                state <= nci_pkg::NCI_TABLE;
              end
              nci_pkg::OP_SNZ: begin
                if (snz_hit) begin
                  skip <= 1'b1;
                end
              end
              nci_pkg::OP_BLA: pc <= {1'b0, op, page_ptr, acc};
              nci_pkg::OP_BMLA: pc <= {1'b0, op, page_ptr, acc};
              nci_pkg::OP_MISC: begin
                case (op)
                  nci_pkg::SUB_AM: acc <= acc + mem;
                  nci_pkg::SUB_AMC: {carry_bit, acc} <= sum_c;
                  nci_pkg::SUB_RAR: begin
                    acc <= {carry_bit, acc[3:1]};
                    carry_bit <= acc[0];
                  end
                  nci_pkg::SUB_SC: carry_bit <= 1'b1;
                  nci_pkg::SUB_RC: carry_bit <= 1'b0;
                  nci_pkg::SUB_TEAB: page_ptr <= page_ptr;
                  nci_pkg::SUB_TABE: {aux, acc} <= tbl_hold;
                  nci_pkg::SUB_READ_DEPTH_POINTER_INSTR: acc <= {1'b0, stack_depth_pointer};
                  nci_pkg::SUB_RT: pc <= return_stack_entry[stack_depth_pointer];
                  nci_pkg::SUB_RTI: begin
                    pc <= return_stack_entry[stack_depth_pointer];
                    {ram_locator, carry_bit, skip, acc, aux} <= interrupt_context_save;
                  end
                  nci_pkg::SUB_SBK: bank <= 1'b1;
                  nci_pkg::SUB_RBK: bank <= 1'b0;
                  nci_pkg::SUB_EI: ei_wait <= 1'b1;
                  nci_pkg::SUB_DI: begin
                    gate <= 1'b0;
                    ei_wait <= 1'b0;
                  end
                  nci_pkg::SUB_TDA: page_ptr <= acc[2:0];
                  nci_pkg::SUB_TAM: acc <= mem;
                  nci_pkg::SUB_AND: acc <= acc & mem;
                  nci_pkg::SUB_OR: acc <= acc | mem;
                  nci_pkg::SUB_CMA: begin
                    if (acc == mem) begin
                      skip <= 1'b1;
                    end
                  end
                  nci_pkg::SUB_TAV1: acc <= enables[3:0];
                  nci_pkg::SUB_TAV2: acc <= enables[7:4];
                  default: acc <= acc;
                endcase
              end
              default: acc <= acc;
            endcase
          end
        end
      end
    end
  end

  // pair register: written by exchange-in, read by exchange-out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tbl_hold <= 8'h00;
    end else if (live && !is_b && !is_bm && major == nci_pkg::OP_MISC && op == nci_pkg::SUB_TEAB) begin
      tbl_hold <= pair;
    end
  end

  // register bus slave
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_fire = s_axi_awready;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign status = '{8'h00, skip, gate, carry_bit, stack_depth_pointer, acc, pc};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= nci_pkg::RESP_OKAY;
    end else begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= s_axi_awaddr[4] ? nci_pkg::RESP_SLVERR : nci_pkg::RESP_OKAY;
        if (s_axi_awaddr == nci_pkg::REG_CTRL && s_axi_wstrb[0]) begin
          run <= s_axi_wdata[0];
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= nci_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= nci_pkg::RESP_OKAY;
      case (s_axi_araddr)
        nci_pkg::REG_CTRL: s_axi_rdata <= {31'h0000_0000, run};
        nci_pkg::REG_STATUS: s_axi_rdata <= status;
        nci_pkg::REG_IRQ_EN: s_axi_rdata <= {24'h00_0000, enables};
        nci_pkg::REG_IRQ_FLAGS: s_axi_rdata <= {24'h00_0000, flags};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= nci_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : nci_core

/* tb/nci_periph.sv */
`timescale 1ns/1ps
module nci_periph (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench control
  input wire logic [nci_pkg::NUM_SRC-1:0] fire,
  input wire logic slow,
  // requests to the core
  output logic [nci_pkg::NUM_SRC-1:0] irq_src
);
  logic [nci_pkg::NUM_SRC-1:0] held;

  // a slow source answers one cycle later, and each request lasts as long as its fire bit is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held <= '0;
      irq_src <= '0;
    end else begin
      held <= fire;
      irq_src <= slow ? held : fire;
    end
  end
endmodule : nci_periph

/* tb/nci_core_properties.sv */
`timescale 1ns/1ps
module nci_core_properties (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [nci_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [nci_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side
  input wire logic [nci_pkg::PC_W-1:0] rom_addr,
  input wire logic [nci_pkg::PORT_D_W-1:0] port_d_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  bad_wr_a: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_awaddr[4]
    |=> s_axi_bresp == nci_pkg::RESP_SLVERR) else $error("unmapped write not refused");
  bad_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4]
    |=> s_axi_rresp == nci_pkg::RESP_SLVERR && s_axi_rdata == '0) else $error("unmapped read not refused");
  ok_rd_a: assert property (s_axi_arvalid && s_axi_arready && !s_axi_araddr[4] && s_axi_araddr[1:0] == 2'h0
    |=> s_axi_rresp == nci_pkg::RESP_OKAY) else $error("mapped read refused");
  stray_b_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_wvalid && s_axi_awready))
    else $error("write response without request");
  rom_pace_a: assert property ($changed(rom_addr) |=> $stable(rom_addr) [*2])
    else $error("fetch address faster than machine cycle");
  reset_out_a: assert property (disable iff (1'b0) !aresetn |=> rom_addr == '0 && port_d_out == '0)
    else $error("outputs not cleared by reset");
endmodule : nci_core_properties

bind nci_core nci_core_properties nci_core_properties_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rom_addr(rom_addr), .port_d_out(port_d_out));

/* tb/nci_core_bench.sv */
`timescale 1ns/1ps
module nci_core_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = '0, araddr = '0;
  logic [2:0] awprot = '0, arprot = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, d;
  logic [13:0] rom_addr;
  logic [9:0] rom_data, port_out;
  logic [9:0] port_in = '0;
  logic [7:0] fire = '0;
  logic [7:0] irq;
  logic [9:0] rom [0:16383];
  nci_pkg::nci_status_t st;
  int fail_count = 0, n_checks = 0, seed = 18, pa, m, a, b, s, cy, msp;

  initial forever #25 aclk = ~aclk;
  assign rom_data = rom[rom_addr];

  nci_core nci_core_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rom_addr(rom_addr), .rom_data(rom_data), .irq_src(irq), .port_d_out(port_out), .port_d_in(port_in));

  nci_periph nci_periph_i (.aclk(aclk), .aresetn(aresetn), .fire(fire), .slow(slow), .irq_src(irq));

  task automatic axw(input logic [4:0] ad, input logic [31:0] wd, input logic [3:0] sb);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= wd;
    wstrb <= sb;
    awprot <= 3'($random(seed));
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [4:0] ad);
    @(posedge aclk);
    araddr <= ad;
    arprot <= 3'($random(seed));
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude;
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // reset the core and blank the low program pages
  task automatic restart;
    @(posedge aclk);
    aresetn <= 1'b0;
    port_in <= 10'($random(seed));
    for (int i = 0; i < 512; i++) rom[i] = 10'h000;
    pa = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : restart

  task automatic put(input logic [9:0] w);
    rom[pa] = w;
    pa++;
  endtask : put

  // run for n clocks so the program parks in its loop, then halt and fetch status
  task automatic run(input int n);
    axw(nci_pkg::REG_CTRL, 32'h0000_0001, 4'hf);
    repeat (n) @(posedge aclk);
    axw(nci_pkg::REG_CTRL, 32'h0000_0000, 4'hf);
    axr(nci_pkg::REG_STATUS);
    st = d;
  endtask : run

  initial begin
    restart();
    axr(nci_pkg::REG_STATUS);
    chk("status_reset", d[23:0], {3'h0, nci_pkg::SP_RESET, 18'h0_0000});
    axw(nci_pkg::REG_IRQ_EN, 32'h0000_00a5, 4'hf);
    axw(nci_pkg::REG_IRQ_EN, 32'h0000_005a, 4'h0);
    axr(nci_pkg::REG_IRQ_EN);
    chk("irq_en", d[7:0], 8'ha5);
    axr(5'h10);
    chk("bad_rd_resp", resp, nci_pkg::RESP_SLVERR);
    chk("bad_rd_data", d, 32'h0000_0000);
    axw(5'h14, 32'hffff_ffff, 4'hf);
    chk("bad_wr_resp", resp, nci_pkg::RESP_SLVERR);
    axr(nci_pkg::REG_IRQ_FLAGS);
    chk("flags_reset", d[7:0], 8'h00);
    repeat (4) begin
      m = $random(seed) & 15;
      a = $random(seed) & 15;
      b = $random(seed) & 15;
      restart();
      put({nci_pkg::OP_LA, 2'h0, 4'(m)});
      put({nci_pkg::OP_MISC, nci_pkg::SUB_TMA});
      put({nci_pkg::OP_LA, 2'h0, 4'(a)});
      put({nci_pkg::OP_MISC, nci_pkg::SUB_RC});
      put({nci_pkg::OP_MISC, nci_pkg::SUB_AMC});
      put({nci_pkg::OP_ADDI, 2'h0, 4'(b)});
      put({nci_pkg::OP_MISC, nci_pkg::SUB_AM});
      put({nci_pkg::OP_MISC, nci_pkg::SUB_RAR});
      put({3'h7, 7'h08});
      s = a + m;
      cy = s >> 4;
      s = ((s & 15) + b + m) & 15;
      a = (cy << 3) | (s >> 1);
      cy = s & 1;
      run(60);
      chk("alu_acc", st.acc, a);
      chk("alu_carry", st.carry, cy);
      chk("alu_pc", st.pc, 14'h0008);
    end
    restart();
    put({nci_pkg::OP_BM, 7'h00});
    for (int k = 0; k < 9; k++) rom[14'h0100 + k] = {nci_pkg::OP_BM, 7'(k + 1)};
    rom[14'h0109] = {nci_pkg::OP_MISC, nci_pkg::SUB_READ_DEPTH_POINTER_INSTR};
    rom[14'h010a] = {3'h7, 7'h0a};
    msp = 7;
    repeat (10) msp = (msp + 1) & 7;
    run(120);
    chk("stack_acc", st.acc, msp);
    chk("stack_sp", st.sp, msp);
    chk("stack_pc", st.pc, 14'h010a);
    restart();
    put({nci_pkg::OP_LY, 2'h0, 4'h3});
    put({nci_pkg::OP_PBIT, nci_pkg::BIT_SET, 4'h0});
    put({nci_pkg::OP_LY, 2'h0, 4'h5});
    put({nci_pkg::OP_PBIT, nci_pkg::BIT_TEST, 4'h0});
    put({nci_pkg::OP_MISC, nci_pkg::SUB_SC});
    put({nci_pkg::OP_LA, 2'h0, 4'h5});
    put({nci_pkg::OP_MISC, nci_pkg::SUB_TDA});
    put({nci_pkg::OP_LA, 2'h0, 4'h3});
    put({nci_pkg::OP_MISC, nci_pkg::SUB_SBK});
    put({nci_pkg::OP_TABP, 6'h01});
    put({nci_pkg::OP_MISC, nci_pkg::SUB_TEAB});
    put({nci_pkg::OP_LA, 2'h0, 4'h0});
    put({nci_pkg::OP_MISC, nci_pkg::SUB_TABE});
    put({3'h7, 7'h0d});
    // low nibble forced nonzero so a missed bank shows up
    s = ($random(seed) & 1023) | 1;
    rom[{1'b1, 6'h01, 3'h5, 4'h3}] = 10'(s);
    run(60);
    chk("port_out", port_out, 10'h008);
    chk("port_skip", st.carry, port_in[5]);
    chk("tbl_acc", st.acc, s & 15);
    chk("tbl_sp", st.sp, 3'h7);
    chk("tbl_pc", st.pc, 14'h000d);
    restart();
    axw(nci_pkg::REG_IRQ_EN, 32'h0000_000c, 4'hf);
    put({nci_pkg::OP_MISC, nci_pkg::SUB_EI});
    put(10'h000);
    put({3'h7, 7'h02});
    rom[14'h0084] = {nci_pkg::OP_MISC, nci_pkg::SUB_EI};
    rom[14'h0085] = {nci_pkg::OP_MISC, nci_pkg::SUB_RTI};
    rom[14'h0086] = {3'h7, 7'h06};
    @(posedge aclk);
    fire <= 8'h02;
    @(posedge aclk);
    fire <= 8'h0c;
    slow <= 1'b1;
    @(posedge aclk);
    fire <= 8'h00;
    repeat (3) @(posedge aclk);
    axr(nci_pkg::REG_IRQ_FLAGS);
    chk("flags_set", d[7:0], 8'h0e);
    run(60);
    chk("irq_pc", st.pc, 14'h0080 + 3 * 2);
    chk("irq_gate", st.gate, 1'b0);
    chk("irq_sp", st.sp, 3'h0);
    axr(nci_pkg::REG_IRQ_FLAGS);
    chk("flags_left", d[7:0], 8'h02);
    conclude();
  end

  initial begin
    repeat (10000) @(posedge aclk);
    fail_count++;
    conclude();
  end
endmodule : nci_core_bench
